// ---- hdl/scsc_pkg.sv ----
// Constants, types and register map of the stop-clock state control block.
//
// Summary of operation
// - Family select bit; second family enables sleep
// - Level-2 read, second family: grant or sleep
// - Level-3 read, second family, deep=0: sleep
// - First family ignores sleep and deep selects
// - Polarity bit: 0 alarm high, 1 low
// - Alarm held two seconds starts duty throttling
// - Software or thermal throttle, one shared period
// - Port read stops clock only if enabled
// - Function select picks software entry state
// - First family: level-2 grant, level-3 halt
// - Software entry: select 0 grant or sleep, 1 halt or deep
// - Snooze enable drives sram snooze output
// - Level-3 read, second family, deep=1: deep
// - All entries need power-management enable bit
package scsc_pkg;
    // ==========================================================
    // Clock and timing
    localparam int CLK_HZ = 200_000_000;  // System clock rate
    localparam int THERM_HOLD_S = 2;  // Alarm qualification, seconds
    localparam int THERM_HOLD_CYC = THERM_HOLD_S * CLK_HZ;
    localparam int THR_STEP_CYC = 32;  // Cycles per throttle phase

    // ==========================================================
    // Register indices and byte addresses
    localparam logic [9:0] IDX_CTL = 10'h07b;  // Stop-clock control
    localparam logic [9:0] IDX_GREEN = 10'h07a;  // Grant state select
    localparam logic [9:0] IDX_SWPORT = 10'h0b2;  // Software entry port
    localparam logic [9:0] IDX_PMCTL = 10'h010;  // Power-management control
    localparam logic [9:0] IDX_L2PORT = 10'h014;  // Level-2 entry port
    localparam logic [9:0] IDX_L3PORT = 10'h015;  // Level-3 entry port
    localparam logic [11:0] ADDR_CTL = {IDX_CTL, 2'h0};
    localparam logic [11:0] ADDR_GREEN = {IDX_GREEN, 2'h0};
    localparam logic [11:0] ADDR_SWPORT = {IDX_SWPORT, 2'h0};
    localparam logic [11:0] ADDR_PMCTL = {IDX_PMCTL, 2'h0};
    localparam logic [11:0] ADDR_L2PORT = {IDX_L2PORT, 2'h0};
    localparam logic [11:0] ADDR_L3PORT = {IDX_L3PORT, 2'h0};
    localparam logic [11:0] ADDR_STATUS = 12'h060;  // State, write resumes

    // ==========================================================
    // Reset values and field positions
    localparam logic [7:0] CTL_RST = 8'h00;
    localparam logic [9:0] PMCTL_RST = 10'h000;
    localparam logic GREEN_RST = 1'b0;
    localparam int PM_EN_BIT = 9;  // Entry methods enable
    localparam int PM_SWTHR_BIT = 4;  // Software throttle enable
    localparam int PM_DUTY_LSB = 1;  // Duty field bits 3:1
    localparam int ST_THR_BIT = 5;  // Status: throttling
    localparam int ST_ALARM_BIT = 6;  // Status: alarm qualified

    // ==========================================================
    // Bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Stop-clock control register fields, bit 7 first
    typedef struct packed {
        logic deep_state_select;
        logic sleep_state_select;
        logic alarm_active_low;
        logic auto_throttle_en;
        logic stop_clock_function_select;
        logic software_stop_clock_enable;
        logic family_second;
        logic snooze_en;
    } scsc_ctl_t;

    // Processor clock states, one-hot
    typedef enum logic [4:0] {
        ST_RUN = 5'h01,
        ST_GRANT = 5'h02,
        ST_HALT = 5'h04,
        ST_SLEEP = 5'h08,
        ST_DEEP = 5'h10
    } scsc_state_t;
endpackage

// ---- hdl/scsc_alarm_qual.sv ----
// Thermal alarm synchroniser and hold-time qualifier.
`timescale 1ns/1ps
module scsc_alarm_qual #(
    parameter int HOLD_CYC = scsc_pkg::THERM_HOLD_CYC
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Pin and configuration
    input wire logic alarm_pin,
    input wire logic active_low,
    input wire logic enable,
    // Result
    output logic qualified
);
    localparam int CW = $clog2(HOLD_CYC + 1);
    localparam logic [CW-1:0] LAST = CW'(HOLD_CYC - 1);

    logic s1_r, s2_r, s3_r;  // Pin synchroniser chain
    logic level_r;  // Agreed pin level
    logic [CW-1:0] cnt_r;  // Active-time counter
    logic active;  // Alarm active after polarity

    // ==========================================================
    // Three-stage synchroniser
    // A change counts only once stages two and three agree
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            level_r <= 1'b0;
        end else begin
            s1_r <= alarm_pin;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                level_r <= s3_r;
            end
        end
    end

    // Polarity selection
    assign active = level_r ^ active_low;

    // ==========================================================
    // Hold counter; any drop restarts the wait
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
            qualified <= 1'b0;
        end else if (!enable || !active) begin
            cnt_r <= '0;
            qualified <= 1'b0;
        end else if (cnt_r == LAST) begin
            qualified <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 1'b1;
        end
    end

    property p_alarm_drop;
        @(posedge clock) disable iff (!rst_n)
        !active |=> !qualified;
    endproperty
    a_alarm_drop: assert property (p_alarm_drop) else $error("qualified without alarm");
endmodule

// ---- hdl/scsc_top.sv ----
// Stop-clock state control with its AXI4-Lite register slave.
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps
module scsc_top #(
    parameter int THERM_HOLD = scsc_pkg::THERM_HOLD_CYC,
    parameter int THR_STEP = scsc_pkg::THR_STEP_CYC
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // AXI4-Lite write address
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Thermal sensor pin
    input wire logic thermal_alarm_n,
    // Processor and memory controls
    output logic cpu_halt_clock_n,
    output logic cpu_sleep_n,
    output logic sram_snooze,
    output logic throttle_active
);
    // ==========================================================
    // Declarations
    localparam int SW = $clog2(THR_STEP + 1);
    localparam logic [SW-1:0] STEP_LAST = SW'(THR_STEP - 1);

    scsc_pkg::scsc_ctl_t ctl_r;  // Stop-clock control
    logic grant_sel_r;  // Grant state select
    logic [9:0] pm_r;  // Power-management control
    scsc_pkg::scsc_state_t state_r, state_nxt;  // Processor state

    logic [11:0] awaddr_r;  // Held write address
    logic [31:0] wdata_r;  // Held write data
    logic [3:0] wstrb_r;  // Held byte enables
    logic aw_full_r, w_full_r;  // Halves of a write held
    logic wr_do;  // Both halves here, no answer pending
    logic rd_hs;  // Read address taken this edge
    logic [31:0] rd_val;  // Read data mux
    logic rd_hit;  // Read address mapped
    logic wr_hit;  // Write address mapped

    logic pm_en;  // Entry methods enabled
    logic alarm_ok;  // Alarm held long enough
    logic thr_on;  // Some throttle source active
    logic [2:0] duty;  // Throttle duty in eighths
    logic [SW-1:0] step_r;  // Cycles within phase
    logic [2:0] phase_r;  // Phase within period
    logic thr_stop;  // Throttle asks clock stopped

    assign pm_en = pm_r[scsc_pkg::PM_EN_BIT];
    assign duty = pm_r[scsc_pkg::PM_DUTY_LSB +: 3];
    assign wr_do = aw_full_r && w_full_r && !s_axi_bvalid;
    assign rd_hs = s_axi_arvalid && s_axi_arready;

    // ==========================================================
    // Write channel capture
    // Address and data may arrive in either order
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            aw_full_r <= 1'b0;
            awaddr_r <= '0;
            s_axi_awready <= 1'b1;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_full_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            aw_full_r <= 1'b0;
            s_axi_awready <= 1'b1;
        end
    end

    // Write data capture
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            w_full_r <= 1'b0;
            wdata_r <= '0;
            wstrb_r <= '0;
            s_axi_wready <= 1'b1;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_full_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            w_full_r <= 1'b0;
            s_axi_wready <= 1'b1;
        end
    end

    // Write address decode
    always_comb begin
        case (awaddr_r)
            scsc_pkg::ADDR_CTL,
            scsc_pkg::ADDR_GREEN,
            scsc_pkg::ADDR_PMCTL,
            scsc_pkg::ADDR_STATUS: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    // ==========================================================
    // Write response
    // Entry ports are read-only; writes there get an error
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= scsc_pkg::RESP_OKAY;
        end else if (wr_do) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? scsc_pkg::RESP_OKAY : scsc_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // ==========================================================
    // Configuration registers
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctl_r <= scsc_pkg::CTL_RST;
            grant_sel_r <= scsc_pkg::GREEN_RST;
            pm_r <= scsc_pkg::PMCTL_RST;
        end else if (wr_do) begin
            if (awaddr_r == scsc_pkg::ADDR_CTL && wstrb_r[0]) begin
                ctl_r <= wdata_r[7:0];
            end
            if (awaddr_r == scsc_pkg::ADDR_GREEN && wstrb_r[0]) begin
                grant_sel_r <= wdata_r[0];
            end
            if (awaddr_r == scsc_pkg::ADDR_PMCTL) begin
                if (wstrb_r[0]) begin
                    pm_r[7:0] <= wdata_r[7:0];
                end
                if (wstrb_r[1]) begin
                    pm_r[9:8] <= wdata_r[9:8];
                end
            end
        end
    end

    // ==========================================================
    // Read data mux; entry ports read as zero
    always_comb begin
        rd_val = '0;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            scsc_pkg::ADDR_CTL: rd_val = {24'h000000, ctl_r};
            scsc_pkg::ADDR_GREEN: rd_val = {31'h00000000, grant_sel_r};
            scsc_pkg::ADDR_PMCTL: rd_val = {22'h000000, pm_r};
            scsc_pkg::ADDR_STATUS: begin
                rd_val[4:0] = state_r;
                rd_val[scsc_pkg::ST_THR_BIT] = thr_on;
                rd_val[scsc_pkg::ST_ALARM_BIT] = alarm_ok;
            end
            scsc_pkg::ADDR_L2PORT,
            scsc_pkg::ADDR_L3PORT,
            scsc_pkg::ADDR_SWPORT: rd_val = '0;
            default: rd_hit = 1'b0;
        endcase
    end

    // Read channel; one read at a time
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= scsc_pkg::RESP_OKAY;
        end else if (rd_hs) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_val;
            s_axi_rresp <= rd_hit ? scsc_pkg::RESP_OKAY : scsc_pkg::RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ==========================================================
    // State decision on entry-port reads
    // Entry only from running; a status write resumes
    always_comb begin
        state_nxt = state_r;
        if (wr_do && awaddr_r == scsc_pkg::ADDR_STATUS) begin
            state_nxt = scsc_pkg::ST_RUN;
        end
        if (rd_hs && pm_en && state_r == scsc_pkg::ST_RUN) begin
            if (s_axi_araddr == scsc_pkg::ADDR_L2PORT) begin
                if (!ctl_r.family_second) begin
                    state_nxt = scsc_pkg::ST_GRANT;
                end else if (ctl_r.sleep_state_select) begin
                    state_nxt = scsc_pkg::ST_SLEEP;
                end else begin
                    state_nxt = scsc_pkg::ST_GRANT;
                end
            end else if (s_axi_araddr == scsc_pkg::ADDR_L3PORT) begin
                if (!ctl_r.family_second) begin
                    state_nxt = scsc_pkg::ST_HALT;
                end else if (ctl_r.deep_state_select) begin
                    state_nxt = scsc_pkg::ST_DEEP;
                end else begin
                    state_nxt = scsc_pkg::ST_SLEEP;
                end
            end else if (s_axi_araddr == scsc_pkg::ADDR_SWPORT &&
                         ctl_r.software_stop_clock_enable) begin
                if (ctl_r.stop_clock_function_select) begin
                    state_nxt = ctl_r.family_second ?
                        scsc_pkg::ST_DEEP : scsc_pkg::ST_HALT;
                end else if (ctl_r.family_second && grant_sel_r) begin
                    state_nxt = scsc_pkg::ST_SLEEP;
                end else begin
                    state_nxt = scsc_pkg::ST_GRANT;
                end
            end
        end
    end

    // State register
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= scsc_pkg::ST_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ==========================================================
    // Thermal alarm qualification
    scsc_alarm_qual #(
        .HOLD_CYC(THERM_HOLD)
    ) u_alarm (
        .clock(clock),
        .rst_n(rst_n),
        .alarm_pin(thermal_alarm_n),
        .active_low(ctl_r.alarm_active_low),
        .enable(ctl_r.auto_throttle_en),
        .qualified(alarm_ok)
    );

    // Either source throttles at the same period
    assign thr_on = pm_r[scsc_pkg::PM_SWTHR_BIT] ||
        (ctl_r.auto_throttle_en && alarm_ok);
    assign thr_stop = thr_on && (phase_r < duty);

    // ==========================================================
    // Throttle period: eight phases of THR_STEP cycles
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            step_r <= '0;
            phase_r <= 3'h0;
        end else if (!thr_on) begin
            step_r <= '0;
            phase_r <= 3'h0;
        end else if (step_r == STEP_LAST) begin
            step_r <= '0;
            phase_r <= phase_r + 3'h1;
        end else begin
            step_r <= step_r + 1'b1;
        end
    end

    // ==========================================================
    // Processor and memory outputs, all registered
    // Sleep pin only serves the second family
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cpu_halt_clock_n <= 1'b1;
            cpu_sleep_n <= 1'b1;
            sram_snooze <= 1'b0;
            throttle_active <= 1'b0;
        end else begin
            cpu_halt_clock_n <= (state_r == scsc_pkg::ST_RUN) && !thr_stop;
            cpu_sleep_n <= !(ctl_r.family_second &&
                (state_r == scsc_pkg::ST_SLEEP || state_r == scsc_pkg::ST_DEEP));
            sram_snooze <= ctl_r.snooze_en && (state_r != scsc_pkg::ST_RUN);
            throttle_active <= thr_on;
        end
    end

    // ==========================================================
    // Checks
    property p_halt_low;
        @(posedge clock) disable iff (!rst_n)
        state_r != scsc_pkg::ST_RUN |=> !cpu_halt_clock_n;
    endproperty
    a_halt_low: assert property (p_halt_low) else $error("halt pin high in low power");

    property p_sleep_family;
        @(posedge clock) disable iff (!rst_n)
        !ctl_r.family_second |=> cpu_sleep_n;
    endproperty
    a_sleep_family: assert property (p_sleep_family) else $error("sleep pin on first family");

    property p_l2_first;
        @(posedge clock) disable iff (!rst_n)
        rd_hs && pm_en && state_r == scsc_pkg::ST_RUN && !ctl_r.family_second &&
        s_axi_araddr == scsc_pkg::ADDR_L2PORT |=> state_r == scsc_pkg::ST_GRANT ##1 !cpu_halt_clock_n;
    endproperty
    a_l2_first: assert property (p_l2_first) else $error("level-2 not grant");

    property p_l2_second;
        @(posedge clock) disable iff (!rst_n)
        rd_hs && pm_en && state_r == scsc_pkg::ST_RUN && ctl_r.family_second &&
        s_axi_araddr == scsc_pkg::ADDR_L2PORT |=>
        state_r == ($past(ctl_r.sleep_state_select) ? scsc_pkg::ST_SLEEP : scsc_pkg::ST_GRANT);
    endproperty
    a_l2_second: assert property (p_l2_second) else $error("level-2 wrong state");

    property p_l3_second;
        @(posedge clock) disable iff (!rst_n)
        rd_hs && pm_en && state_r == scsc_pkg::ST_RUN && ctl_r.family_second &&
        s_axi_araddr == scsc_pkg::ADDR_L3PORT |=>
        state_r == ($past(ctl_r.deep_state_select) ? scsc_pkg::ST_DEEP : scsc_pkg::ST_SLEEP);
    endproperty
    a_l3_second: assert property (p_l3_second) else $error("level-3 wrong state");

    property p_no_enable;
        @(posedge clock) disable iff (!rst_n)
        state_r == scsc_pkg::ST_RUN && !pm_en |=> state_r == scsc_pkg::ST_RUN;
    endproperty
    a_no_enable: assert property (p_no_enable) else $error("entry while disabled");

    property p_sw_off;
        @(posedge clock) disable iff (!rst_n)
        rd_hs && state_r == scsc_pkg::ST_RUN && !ctl_r.software_stop_clock_enable &&
        s_axi_araddr == scsc_pkg::ADDR_SWPORT |=> state_r == scsc_pkg::ST_RUN;
    endproperty
    a_sw_off: assert property (p_sw_off) else $error("port read acted while disabled");

    property p_snooze;
        @(posedge clock) disable iff (!rst_n)
        !ctl_r.snooze_en |=> !sram_snooze;
    endproperty
    a_snooze: assert property (p_snooze) else $error("snooze without enable");
endmodule

// ---- sim/scsc_cpu_model.sv ----
// Processor core model that watches the stop-clock and sleep pins.
`timescale 1ns/1ps
module scsc_cpu_model (
    // Clock and reset
    input wire logic clock,
    input wire logic rst_n,
    // Pins from the block
    input wire logic cpu_halt_clock_n,
    input wire logic cpu_sleep_n,
    input wire logic sram_snooze,
    // Core view of its own condition
    output logic core_running,
    output logic core_asleep,
    output logic sram_off
);
    // ==========================================================
    // Pin sampling
    // Registered, like a real core latching its pins at its clock
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            core_running <= 1'b1;
            core_asleep <= 1'b0;
            sram_off <= 1'b0;
        end else begin
            core_running <= cpu_halt_clock_n;
            // Sleep only counts while the halt-clock pin is sampled low in the same cycle
            core_asleep <= !cpu_sleep_n && !cpu_halt_clock_n;
            sram_off <= sram_snooze;
        end
    end
endmodule

// ---- sim/tb.sv ----
// Self-checking bench for the stop-clock state control block.
`timescale 1ns/1ps
module tb;
    // ==========================================================
    // Signals
    logic clock = 1'b0;
    logic rst_n = 1'b0;
    logic [11:0] awaddr = 12'h000;
    logic awvalid = 1'b0;
    logic awready;
    logic [31:0] wdata = 32'h0;
    logic wvalid = 1'b0;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic [11:0] araddr = 12'h000;
    logic arvalid = 1'b0;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic alarm = 1'b1;  // Inactive with low-active polarity
    logic halt_n, sleep_n, snooze, thr;
    logic running, asleep, sram_off;
    logic [31:0] d;  // Last read data
    logic [1:0] r;  // Last response
    int n_errors = 0;
    int tests_run = 0;
    int lows;  // Halt-low samples in a throttle period

    // ==========================================================
    // Design and core model
    scsc_top #(.THERM_HOLD(20), .THR_STEP(2)) dut_u (
        .clock(clock), .rst_n(rst_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .thermal_alarm_n(alarm),
        .cpu_halt_clock_n(halt_n), .cpu_sleep_n(sleep_n), .sram_snooze(snooze),
        .throttle_active(thr));
    scsc_cpu_model cpu_u (
        .clock(clock), .rst_n(rst_n), .cpu_halt_clock_n(halt_n),
        .cpu_sleep_n(sleep_n), .sram_snooze(snooze),
        .core_running(running), .core_asleep(asleep), .sram_off(sram_off));

    // ==========================================================
    // Clock, 5 ns period
    initial begin
        forever #2.5 clock = ~clock;
    end

    // ==========================================================
    // Checking and closing
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic stop_test;
        $display("compares %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ==========================================================
    // Bus tasks; ready lines held high, so answers are taken at once
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= v;
        wvalid <= 1'b1;
        // Each channel released only at its own take
        do begin
            @(posedge clock);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        r = bresp;
    endtask

    task automatic rd(input logic [11:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge clock);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        r = rresp;
    endtask

    // One entry attempt: configure, hit the port, check, resume
    task automatic entry(input logic [7:0] ctl, input logic [9:0] pm,
                         input logic [11:0] port, input logic [4:0] st);
        wr(scsc_pkg::ADDR_CTL, {24'h0, ctl});
        wr(scsc_pkg::ADDR_PMCTL, {22'h0, pm});
        rd(port);
        rd(scsc_pkg::ADDR_STATUS);
        chk({27'h0, d[4:0]}, {27'h0, st});
        repeat (2) @(posedge clock);
        chk({31'h0, running}, {31'h0, st == scsc_pkg::ST_RUN});
        chk({31'h0, asleep}, {31'h0, ctl[1] && st[4:3] != 2'h0});
        chk({31'h0, sram_off}, {31'h0, ctl[0] && st != scsc_pkg::ST_RUN});
        wr(scsc_pkg::ADDR_STATUS, 32'h0);
    endtask

    // ==========================================================
    // Watchdog, far beyond the few hundred cycles needed
    initial begin
        repeat (20000) @(posedge clock);
        n_errors++;
        stop_test();
    end

    // ==========================================================
    // Test sequence
    initial begin
        repeat (20) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        rd(scsc_pkg::ADDR_CTL);
        chk(d, 32'h0);
        rd(12'hffc);
        chk({30'h0, r}, {30'h0, scsc_pkg::RESP_SLVERR});
        wr(scsc_pkg::ADDR_L2PORT, 32'h0);
        chk({30'h0, r}, {30'h0, scsc_pkg::RESP_SLVERR});
        $display("test reset and map done");
        entry(8'h00, 10'h200, scsc_pkg::ADDR_L2PORT, scsc_pkg::ST_GRANT);
        entry(8'h00, 10'h200, scsc_pkg::ADDR_L3PORT, scsc_pkg::ST_HALT);
        entry(8'hc0, 10'h200, scsc_pkg::ADDR_L3PORT, scsc_pkg::ST_HALT);
        entry(8'hc0, 10'h200, scsc_pkg::ADDR_L2PORT, scsc_pkg::ST_GRANT);
        entry(8'h02, 10'h200, scsc_pkg::ADDR_L2PORT, scsc_pkg::ST_GRANT);
        entry(8'h43, 10'h200, scsc_pkg::ADDR_L2PORT, scsc_pkg::ST_SLEEP);
        entry(8'h02, 10'h200, scsc_pkg::ADDR_L3PORT, scsc_pkg::ST_SLEEP);
        entry(8'h82, 10'h200, scsc_pkg::ADDR_L3PORT, scsc_pkg::ST_DEEP);
        entry(8'h83, 10'h000, scsc_pkg::ADDR_L3PORT, scsc_pkg::ST_RUN);
        entry(8'h01, 10'h200, scsc_pkg::ADDR_SWPORT, scsc_pkg::ST_RUN);
        entry(8'h05, 10'h200, scsc_pkg::ADDR_SWPORT, scsc_pkg::ST_GRANT);
        entry(8'h0c, 10'h200, scsc_pkg::ADDR_SWPORT, scsc_pkg::ST_HALT);
        entry(8'h0e, 10'h200, scsc_pkg::ADDR_SWPORT, scsc_pkg::ST_DEEP);
        // Grant select set: second-family software entry goes to sleep
        wr(scsc_pkg::ADDR_GREEN, 32'h1);
        rd(scsc_pkg::ADDR_GREEN);
        chk(d, 32'h1);
        entry(8'h06, 10'h200, scsc_pkg::ADDR_SWPORT, scsc_pkg::ST_SLEEP);
        wr(scsc_pkg::ADDR_GREEN, 32'h0);
        $display("test entry table done");
        // Software throttle, duty 4 of 8 phases of 2 cycles
        wr(scsc_pkg::ADDR_PMCTL, 32'h18);
        repeat (4) @(posedge clock);
        chk({31'h0, thr}, 32'h1);
        lows = 0;
        repeat (16) begin
            @(posedge clock);
            lows += int'(!halt_n);
        end
        chk(lows, 32'd8);
        wr(scsc_pkg::ADDR_PMCTL, 32'h6);
        repeat (4) @(posedge clock);
        chk({31'h0, thr}, 32'h0);
        $display("test software throttle done");
        // Auto throttle with alarm low-active: pin high is quiet
        wr(scsc_pkg::ADDR_CTL, 32'h30);
        repeat (40) @(posedge clock);
        chk({31'h0, thr}, 32'h0);
        alarm <= 1'b0;
        repeat (10) @(posedge clock);
        chk({31'h0, thr}, 32'h0);
        repeat (30) @(posedge clock);
        chk({31'h0, thr}, 32'h1);
        rd(scsc_pkg::ADDR_STATUS);
        chk({31'h0, d[scsc_pkg::ST_ALARM_BIT]}, 32'h1);
        // Same pin level under high-active polarity is quiet again
        wr(scsc_pkg::ADDR_CTL, 32'h10);
        repeat (40) @(posedge clock);
        chk({31'h0, thr}, 32'h0);
        $display("test thermal throttle done");
        stop_test();
    end
endmodule
